// ===== mac_pkg.sv
`default_nettype none
package mac_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] MAC_OFF_CONFIG  = 8'h00;
  localparam logic [7:0] MAC_OFF_STATUS  = 8'h04;
  localparam logic [7:0] MAC_OFF_OPA_HI  = 8'h08;
  localparam logic [7:0] MAC_OFF_OPA_LO  = 8'h0c;
  localparam logic [7:0] MAC_OFF_OPB_HI  = 8'h10;
  localparam logic [7:0] MAC_OFF_OPB_LO  = 8'h14;
  localparam logic [7:0] MAC_OFF_ACC_TOP = 8'h18;
  localparam logic [7:0] MAC_OFF_ACC3    = 8'h1c;
  localparam logic [7:0] MAC_OFF_ACC2    = 8'h20;
  localparam logic [7:0] MAC_OFF_ACC1    = 8'h24;
  localparam logic [7:0] MAC_OFF_ACC0    = 8'h28;
  localparam logic [7:0] MAC_OFF_RND_HI  = 8'h2c;
  localparam logic [7:0] MAC_OFF_RND_LO  = 8'h30;
  // config bit positions
  localparam int MAC_CF_MS  = 0;
  localparam int MAC_CF_FM  = 1;
  localparam int MAC_CF_SAT = 2;
  localparam int MAC_CF_CA  = 3;
  localparam int MAC_CF_SD  = 4;
  localparam int MAC_CF_SC  = 5;
  localparam logic [5:0] MAC_CF_RESET = 6'h00;
  // status bit positions
  localparam int MAC_ST_N  = 0;
  localparam int MAC_ST_SO = 1;
  localparam int MAC_ST_Z  = 2;
  localparam int MAC_ST_HO = 3;
  localparam logic [3:0] MAC_ST_RESET = 4'h4;
  // rounding constants
  localparam logic [15:0] MAC_RND_HALF = 16'h8000;
  localparam logic [15:0] MAC_SAT_POS  = 16'h7fff;
  localparam logic [15:0] MAC_SAT_NEG  = 16'h8000;
endpackage : mac_pkg
`default_nettype wire

// ===== mac_engine.sv
// Notes on behaviour
// - signed 16x16 multiply added into a 40-bit path, done in two clocks.
// - format bit 0 means integer operands and integer accumulator.
// - format bit 1 means Q15 operands, accumulator point between bits 31 and 30.
// - accumulate mode adds product to the accumulator and stores the sum.
// - writing operand b low byte starts a three-stage pipeline, one clock each.
// - stage one multiplies, stage two adds and sets flags, stage three rounds.
// - a new start is accepted while the previous operation is in stage three.
// - rounded 16-bit result is valid at the end of stage three.
// - clear bit at start zeroes accumulator and flags, then clears itself.
// - multiply-only mode overwrites the accumulator with the product.
// - multiply-only mode leaves hard overflow flag unchanged.
// - shift-start shifts accumulator in one clock, rounding next clock, bit self-clears.
// - direction 0 shifts left, 1 shifts right with bit 39 copied.
// - shifts change no status flag.
// - round bits 31-16 up when low half above 0x8000, or equal and bit 16 set.
// - rounding recomputed in stage three, after a shift, and on accumulator byte 0 write.
// - rounding never changes the accumulator and ignores format.
// - saturate gives 0x7fff or 0x8000 on overflow; off means no saturation.
// - accumulator visible as five read/write byte registers.
// - rounding register holds 16 low bits; sign is the negative flag.
// - hard overflow sets on overflow out of top byte, sticky until cleared.
`default_nettype none
module mac_engine
  import mac_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ACC_W  = 40
)(
  // clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic             PREADY_OUT,
  output logic [31:0]      PRDATA_OUT,
  output logic             PSLVERR_OUT,
  // status
  output logic             BUSY_OUT
);
  import mac_pkg::*;

  // the datapath below is written for the documented widths only
  if (DATA_W != 16 || ACC_W != 40)
  begin : g_bad_size
    $error("mac_engine supports only 16-bit operands and a 40-bit accumulator");
  end

  typedef struct packed {
    logic [5:0]  cfg;
    logic [3:0]  sta;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [39:0] acc;
    logic [15:0] rnd;
    logic [31:0] prod;
    logic        s1;
    logic        s1_ms;
    logic        s1_fm;
    logic        s2;
    logic        s3;
    logic        busy;
    logic        rnd_req;
    logic        sh_done;
    logic        ready;
    logic [31:0] rdata;
    logic        slverr;
  } mac_state_s;

  mac_state_s st;
  mac_state_s next_st;

  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  logic [31:0] prod_c;
  logic [39:0] addend;
  logic [39:0] sum;
  logic        ovf_top;
  logic        ovf_low;
  logic [16:0] rnd_inc;
  logic [15:0] rnd_c;
  logic        rnd_up;
  logic        rnd_ovf;
  logic [39:0] acc_view;
  logic [31:0] rd_word;
  logic        wr_cfg;
  logic        wr_sta;
  logic        wr_opa_hi;
  logic        wr_opa_lo;
  logic        wr_opb_hi;
  logic        wr_opb_lo;
  logic        wr_top;
  logic        wr_b3;
  logic        wr_b2;
  logic        wr_b1;
  logic        wr_b0;
  logic        start_op;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers
  always_comb
  begin
    // fractional mode shifts the product left by one to align Q15*Q15 at bit 30
    // operands sign-extended to full width so the product is formed at 32 bits
    prod_c = 32'($signed({{16{st.opa[15]}}, st.opa}) * $signed({{16{st.opb[15]}}, st.opb}));
    addend = st.s1_fm ? {{7{st.prod[31]}}, st.prod, 1'b0}
                      : {{8{st.prod[31]}}, st.prod};
    // accumulator value that stage two will store; rounding reads it back from the register in stage three
    sum     = (st.s1_ms ? 40'h0 : st.acc) + addend;
    ovf_top = (~st.s1_ms) & (st.acc[39] == addend[39]) & (sum[39] != st.acc[39]);
    ovf_low = (sum[39:31] != {9{sum[31]}});
    acc_view = st.acc;
    // unbiased rounding on bits 31-16
    rnd_up  = (acc_view[15:0] > MAC_RND_HALF) ||
              ((acc_view[15:0] == MAC_RND_HALF) && acc_view[16]);
    rnd_inc = {1'b0, acc_view[31:16]} + {16'h0, rnd_up};
    // overflow when the rounded value does not fit a signed 16-bit word
    rnd_ovf = (acc_view[39:31] != {9{acc_view[31]}}) ||
              (rnd_up && acc_view[31:16] == MAC_SAT_POS);
    if (st.cfg[MAC_CF_SAT] && rnd_ovf)
      rnd_c = acc_view[39] ? MAC_SAT_NEG : MAC_SAT_POS;
    else
      rnd_c = rnd_inc[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  always_comb
  begin
    mapped = 1'b1;
    case (PADDR_IN)
      MAC_OFF_CONFIG, MAC_OFF_STATUS, MAC_OFF_OPA_HI, MAC_OFF_OPA_LO,
      MAC_OFF_OPB_HI, MAC_OFF_OPB_LO, MAC_OFF_ACC_TOP, MAC_OFF_ACC3,
      MAC_OFF_ACC2, MAC_OFF_ACC1, MAC_OFF_ACC0, MAC_OFF_RND_HI, MAC_OFF_RND_LO:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
    // a write lands at the edge that completes the transfer, with ready high
    wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN & st.ready & mapped;
    rd_acc = PSEL_IN & PENABLE_IN & ~PWRITE_IN & ~st.ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write strobes, one per writable register
  always_comb
  begin
    wr_cfg    = 1'b0;
    wr_sta    = 1'b0;
    wr_opa_hi = 1'b0;
    wr_opa_lo = 1'b0;
    wr_opb_hi = 1'b0;
    wr_opb_lo = 1'b0;
    wr_top    = 1'b0;
    wr_b3     = 1'b0;
    wr_b2     = 1'b0;
    wr_b1     = 1'b0;
    wr_b0     = 1'b0;
    if (wr_acc)
    begin
      case (PADDR_IN)
        MAC_OFF_CONFIG:
        begin
          wr_cfg = 1'b1;
        end
        MAC_OFF_STATUS:
        begin
          wr_sta = 1'b1;
        end
        MAC_OFF_OPA_HI:
        begin
          wr_opa_hi = 1'b1;
        end
        MAC_OFF_OPA_LO:
        begin
          wr_opa_lo = 1'b1;
        end
        MAC_OFF_OPB_HI:
        begin
          wr_opb_hi = 1'b1;
        end
        MAC_OFF_OPB_LO:
        begin
          wr_opb_lo = 1'b1;
        end
        MAC_OFF_ACC_TOP:
        begin
          wr_top = 1'b1;
        end
        MAC_OFF_ACC3:
        begin
          wr_b3 = 1'b1;
        end
        MAC_OFF_ACC2:
        begin
          wr_b2 = 1'b1;
        end
        MAC_OFF_ACC1:
        begin
          wr_b1 = 1'b1;
        end
        MAC_OFF_ACC0:
        begin
          wr_b0 = 1'b1;
        end
        default:
        begin
          wr_b0 = 1'b0;
        end
      endcase
    end
    // the operand b low byte write is the start of an operation
    start_op = wr_opb_lo;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer
  always_comb
  begin
    rd_word = 32'h0;
    case (PADDR_IN)
      MAC_OFF_CONFIG:  rd_word = {26'h0, st.cfg};
      MAC_OFF_STATUS:  rd_word = {28'h0, st.sta};
      MAC_OFF_OPA_HI:  rd_word = {24'h0, st.opa[15:8]};
      MAC_OFF_OPA_LO:  rd_word = {24'h0, st.opa[7:0]};
      MAC_OFF_OPB_HI:  rd_word = {24'h0, st.opb[15:8]};
      MAC_OFF_OPB_LO:  rd_word = {24'h0, st.opb[7:0]};
      MAC_OFF_ACC_TOP: rd_word = {24'h0, st.acc[39:32]};
      MAC_OFF_ACC3:    rd_word = {24'h0, st.acc[31:24]};
      MAC_OFF_ACC2:    rd_word = {24'h0, st.acc[23:16]};
      MAC_OFF_ACC1:    rd_word = {24'h0, st.acc[15:8]};
      MAC_OFF_ACC0:    rd_word = {24'h0, st.acc[7:0]};
      MAC_OFF_RND_HI:  rd_word = {24'h0, st.rnd[15:8]};
      MAC_OFF_RND_LO:  rd_word = {24'h0, st.rnd[7:0]};
      default:         rd_word = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_st         = st;
    next_st.ready   = PSEL_IN & PENABLE_IN & ~st.ready;
    next_st.slverr  = PSEL_IN & PENABLE_IN & ~st.ready & ~mapped;
    next_st.s1      = start_op;
    next_st.s2      = st.s1;
    next_st.s3      = st.s2;
    next_st.rnd_req = wr_b0;
    next_st.sh_done = 1'b0;

    // stage one: product of the operands as they stand after the start write
    if (st.s1)
    begin
      next_st.prod = prod_c;
    end

    // stage three, a finished shift or an accumulator byte 0 write: rounding
    if (st.s3 || st.sh_done || st.rnd_req)
    begin
      next_st.rnd = rnd_c;
    end

    // accumulator shift, flags untouched; ahead of writes so a new shift bit survives
    if (st.cfg[MAC_CF_SC])
    begin
      next_st.acc = st.cfg[MAC_CF_SD] ? {st.acc[39], st.acc[39:1]}
                                      : {st.acc[38:0], 1'b0};
      next_st.cfg[MAC_CF_SC] = 1'b0;
      next_st.sh_done = 1'b1;
    end

    // software writes
    if (wr_cfg)
    begin
      next_st.cfg = PWDATA_IN[5:0];
    end
    if (wr_sta)
    begin
      next_st.sta = PWDATA_IN[3:0];
    end
    if (wr_opa_hi)
    begin
      next_st.opa[15:8] = PWDATA_IN[7:0];
    end
    if (wr_opa_lo)
    begin
      next_st.opa[7:0] = PWDATA_IN[7:0];
    end
    if (wr_opb_hi)
    begin
      next_st.opb[15:8] = PWDATA_IN[7:0];
    end
    if (wr_opb_lo)
    begin
      next_st.opb[7:0] = PWDATA_IN[7:0];
    end
    if (wr_top)
    begin
      next_st.acc[39:32] = PWDATA_IN[7:0];
    end
    if (wr_b3)
    begin
      next_st.acc[31:24] = PWDATA_IN[7:0];
    end
    if (wr_b2)
    begin
      next_st.acc[23:16] = PWDATA_IN[7:0];
    end
    if (wr_b1)
    begin
      next_st.acc[15:8] = PWDATA_IN[7:0];
    end
    if (wr_b0)
    begin
      next_st.acc[7:0] = PWDATA_IN[7:0];
    end

    // stage two: add and write flags; after the status write so a set wins
    if (st.s2)
    begin
      next_st.acc = sum;
      next_st.sta[MAC_ST_Z]  = (sum == 40'h0);
      next_st.sta[MAC_ST_N]  = sum[39];
      next_st.sta[MAC_ST_SO] = ovf_low;
      if (ovf_top)
      begin
        next_st.sta[MAC_ST_HO] = 1'b1;
      end
    end

    // a start latches the mode bits and applies a pending clear
    if (start_op)
    begin
      next_st.s1_ms = st.cfg[MAC_CF_MS];
      next_st.s1_fm = st.cfg[MAC_CF_FM];
      if (st.cfg[MAC_CF_CA])
      begin
        next_st.acc = 40'h0;
        next_st.sta = 4'h0;
        next_st.cfg[MAC_CF_CA] = 1'b0;
      end
    end

    // read data, captured in the first access cycle
    if (rd_acc)
    begin
      next_st.rdata = rd_word;
    end

    // busy follows the first two stages, registered for a clean output
    next_st.busy = next_st.s1 | next_st.s2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      st         <= '0;
      st.cfg     <= MAC_CF_RESET;
      st.sta     <= MAC_ST_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb
  begin
    PREADY_OUT  = st.ready;
    PRDATA_OUT  = st.rdata;
    PSLVERR_OUT = st.slverr;
    BUSY_OUT    = st.busy;
  end
endmodule : mac_engine
`default_nettype wire

// ===== mac_engine_props.sv
`default_nettype none
module mac_engine_props
  import mac_pkg::*;
(
  // clock and reset
  input wire logic        CLOCK_IN,
  input wire logic        RST_IN,
  // apb side
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic        PREADY_OUT,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PSLVERR_OUT,
  // engine
  input wire logic        BUSY_OUT
);
  logic rd;
  assign rd = PREADY_OUT && !PWRITE_IN;
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////////////////////////////
  a_ready_late: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN && $past(PENABLE_IN))
    else $error("ready outside the access wait");
  a_one_wait: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
    else $error("ready not after one wait");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  a_err_map: assert property (PREADY_OUT && PADDR_IN[1:0] == 2'b00 |-> PSLVERR_OUT == (PADDR_IN > 8'h30))
    else $error("error flag wrong for address");
  a_err_zero: assert property (rd && PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
    else $error("refused read not zero");
  a_start_busy: assert property (PREADY_OUT && PWRITE_IN && PADDR_IN == MAC_OFF_OPB_LO |=> BUSY_OUT [*2] ##1 !BUSY_OUT)
    else $error("pipeline not two busy cycles");
  a_shift_clear: assert property (rd && PADDR_IN == MAC_OFF_CONFIG |-> PRDATA_OUT[31:6] == 26'h0 && !PRDATA_OUT[MAC_CF_SC])
    else $error("shift bit not cleared");
  a_stat_width: assert property (rd && PADDR_IN == MAC_OFF_STATUS |-> PRDATA_OUT[31:4] == 28'h0)
    else $error("status upper bits set");
  a_byte_width: assert property (rd && PADDR_IN > MAC_OFF_STATUS |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("byte register too wide");
endmodule // mac_engine_props
`default_nettype wire

// ===== mac_apb_host.sv
`default_nettype none
module mac_apb_host (
  // clock
  input  wire logic        clk_in,
  // slave answer
  input  wire logic        ready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic        err_in,
  // request
  output logic             sel_out,
  output logic             en_out,
  output logic             write_out,
  output logic [7:0]       addr_out,
  output logic [31:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sel_out = 1'b0;
    en_out = 1'b0;
    write_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 32'h0;
  end
  ////////////////////////////////////////////////////////////////
  // one transfer, held until ready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    sel_out <= 1'b1;
    write_out <= w;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    en_out <= 1'b1;
    // wait for the answer; only the bench watchdog ends a hung wait
    do
    begin
      @(posedge clk_in);
    end
    while (!ready_in);
    q = rdata_in;
    e = err_in;
    sel_out <= 1'b0;
    en_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
endmodule // mac_apb_host
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mac_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        perr;
  logic        busy;
  logic [31:0] q;
  logic        e;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [7:0]  rcfg [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04};
  logic [39:0] racv [6] = '{40'h18000, 40'h28000, 40'h38001, 40'h7fffffff, 40'h7fffffff, 40'hff7fff0000};
  logic [15:0] rexp [6] = '{16'h0002, 16'h0002, 16'h0004, 16'h8000, 16'h7fff, 16'h8000};
  mac_engine dut_u (.CLOCK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
    .PSLVERR_OUT(perr), .BUSY_OUT(busy));
  mac_apb_host m_u (.clk_in(clk), .ready_in(pready), .rdata_in(prdata), .err_in(perr), .sel_out(psel),
    .en_out(pen), .write_out(pwr), .addr_out(paddr), .wdata_out(pwdata));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      bad_count++;
      $display("wrong value at %0t: %h, expected %h", $time, s, x);
    end
  endtask
  // write, or read and compare with d
  task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
    m_u.xfer(w, a, d, q, e);
    if (!w)
      chk(q, d);
  endtask
  task automatic acc(input logic w, input logic [39:0] v);
    for (int i = 0; i < 5; i++)
      io(w, MAC_OFF_ACC_TOP + 8'(4 * i), {24'h0, v[39 - 8 * i -: 8]});
  endtask
  task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [15:0] b);
    io(1'b1, MAC_OFF_CONFIG, {24'h0, c});
    io(1'b1, MAC_OFF_OPA_HI, {24'h0, a[15:8]});
    io(1'b1, MAC_OFF_OPA_LO, {24'h0, a[7:0]});
    io(1'b1, MAC_OFF_OPB_HI, {24'h0, b[15:8]});
    io(1'b1, MAC_OFF_OPB_LO, {24'h0, b[7:0]});
  endtask
  task automatic rnd(input logic [15:0] x);
    io(1'b0, MAC_OFF_RND_HI, {24'h0, x[15:8]});
    io(1'b0, MAC_OFF_RND_LO, {24'h0, x[7:0]});
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #50000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    io(1'b0, MAC_OFF_CONFIG, 32'h0);
    io(1'b0, MAC_OFF_STATUS, 32'h4);
    op(8'h01, 16'h1234, 16'hfedc);
    acc(1'b0, 40'hffffeb3cb0);
    io(1'b0, MAC_OFF_STATUS, 32'h1);
    rnd(16'hffeb);
    op(8'h0a, 16'h4000, 16'h2000);
    io(1'b1, MAC_OFF_OPB_HI, 32'he0);
    io(1'b1, MAC_OFF_OPB_LO, 32'h0);
    acc(1'b0, 40'h0);
    io(1'b0, MAC_OFF_STATUS, 32'h4);
    acc(1'b1, 40'h4088442211);
    io(1'b1, MAC_OFF_CONFIG, 32'h20);
    acc(1'b0, 40'h8110884422);
    io(1'b1, MAC_OFF_CONFIG, 32'h30);
    io(1'b1, MAC_OFF_CONFIG, 32'h30);
    acc(1'b0, 40'he044221108);
    rnd(16'h4422);
    io(1'b0, MAC_OFF_STATUS, 32'h4);
    for (int i = 0; i < 6; i++)
    begin
      io(1'b1, MAC_OFF_CONFIG, {24'h0, rcfg[i]});
      acc(1'b1, racv[i]);
      rnd(rexp[i]);
    end
    acc(1'b1, 40'h7fffffffff);
    op(8'h00, 16'h7fff, 16'h7fff);
    io(1'b0, MAC_OFF_STATUS, 32'h0b);
    acc(1'b0, 40'h803fff0000);
    op(8'h01, 16'h0001, 16'h0001);
    io(1'b0, MAC_OFF_STATUS, 32'h08);
    io(1'b1, MAC_OFF_STATUS, 32'h0);
    io(1'b0, MAC_OFF_STATUS, 32'h0);
    m_u.xfer(1'b0, 8'h3c, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    wrap_up;
  end
endmodule // testbench
bind mac_engine mac_engine_props props_u (.CLOCK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN,
  .PWDATA_IN, .PREADY_OUT, .PRDATA_OUT, .PSLVERR_OUT, .BUSY_OUT);
`default_nettype wire
